// ### include/ids_pkg.sv
// constants for the internal data space and dual data pointer block
// assumes a single-clock cpu core issuing one access per cycle
// Notes on behaviour
// - lower 128 bytes answer direct and indirect
// - lowest 32 bytes are four register banks
// - bank code picks 00h, 08h, 10h or 18h
// - 16 bytes above banks are bit addressable
// - upper 128 bytes only by indirect access
// - direct 80h-FFh goes to function registers
// - 256-byte expanded ram only by external moves
// - ram contents unknown until software writes
// - two 16-bit pointers seen at 83h/84h
// - select bit picks pointer for every use
// - increment of aux register toggles select
// - aux register A2h, select bit 0, bit2 zero
// - bank select in status word bits 4:3
`default_nettype none
package ids_pkg;
  localparam logic [7:0] IDS_ADDR_PTR_HIGH = 8'h83;
  localparam logic [7:0] IDS_ADDR_PTR_LOW = 8'h84;
  localparam logic [7:0] IDS_ADDR_AUX = 8'hA2;
  localparam logic [7:0] IDS_ADDR_PSW = 8'hD0;
  localparam logic [7:0] IDS_BIT_AREA_BASE = 8'h20;
  localparam int IDS_BANK_LSB = 3;
  localparam int IDS_SEL_BIT = 0;
  localparam logic [7:0] IDS_PSW_RESET = 8'h00;
  localparam logic [7:0] IDS_AUX_RESET = 8'h00;
  localparam logic [7:0] IDS_AUX_MASK = 8'h29;
  localparam logic [15:0] IDS_PTR_RESET = 16'h0000;
  localparam int IDS_RAM_DEPTH = 256;
  localparam int IDS_EXPANDED_RAM_DEPTH = 256;
  typedef enum logic [2:0] {
    IDS_OP_NONE,
    IDS_OP_DIRECT,
    IDS_OP_INDIRECT,
    IDS_OP_REG,
    IDS_OP_BIT,
    IDS_OP_XDATA
  } ids_op_type;
endpackage
`default_nettype wire

// ### src/ids_ram.sv
// single-port byte memory, write on clock, registered read
// assumes caller gives one address per cycle
`default_nettype none
module ids_ram #(
  parameter int DEPTH = 256,
  parameter int AW = 8
) (
  input wire logic clk_sys,
  input wire logic wr_en,
  input wire logic [AW-1:0] addr,
  input wire logic [7:0] wr_data,
  output logic [7:0] rd_data
);
  // no reset on purpose: contents stay unknown until written
  logic [7:0] mem_q [DEPTH];
  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem_q[addr] <= wr_data;
    end
    rd_data <= mem_q[addr];
  end
endmodule // ids_ram
`default_nettype wire

// ### src/ids_data_space.sv
// internal data space decoder with banked registers and dual data pointer
// assumes the cpu core holds op/addr/data for one cycle per access
`default_nettype none
module ids_data_space (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic acc_valid,
  input wire ids_pkg::ids_op_type acc_op,
  input wire logic acc_write,
  input wire logic [7:0] acc_addr,
  input wire logic [7:0] acc_wdata,
  input wire logic acc_bit_value,
  input wire logic ptr_increment,
  input wire logic aux_increment,
  input wire logic [7:0] sfr_rdata,
  output logic rd_valid,
  output logic [7:0] rd_data,
  output logic rd_bit,
  output logic sfr_write,
  output logic sfr_read,
  output logic [7:0] sfr_addr,
  output logic [7:0] sfr_wdata,
  output logic [15:0] data_pointer,
  output logic [1:0] bank_select,
  output logic pointer_select
);
  typedef enum logic [1:0] {
    IDS_SRC_NONE,
    IDS_SRC_RAM,
    IDS_SRC_EXPANDED_RAM,
    IDS_SRC_SFR
  } ids_src_type;

  // bit address to byte address inside the bit area
  function automatic logic [7:0] ids_bit_byte(input logic [7:0] b);
    ids_bit_byte = ids_pkg::IDS_BIT_AREA_BASE + {3'h0, b[6:2] >> 1};
  endfunction

  logic [7:0] psw_q, psw_d;
  logic [7:0] aux_q, aux_d;
  logic [15:0] ptr0_q, ptr0_d, ptr1_q, ptr1_d;
  logic [7:0] ram_addr, ram_wdata, ram_rdata, expanded_ram_rdata;
  logic ram_we, expanded_ram_we;
  logic [2:0] bit_pos_q, bit_pos_d;
  logic bit_op_q, bit_op_d;
  ids_src_type src_q, src_d;
  logic [7:0] sfr_data_q, sfr_data_d;
  logic sfr_wr_q, sfr_wr_d, sfr_rd_q, sfr_rd_d;
  logic [7:0] sfr_addr_q, sfr_addr_d, sfr_wd_q, sfr_wd_d;
  logic [15:0] sel_ptr;
  // registered copy of the next selected pointer: a flop output, no lag
  logic [15:0] data_pointer_q, data_pointer_d;
  logic [7:0] bit_byte;
  logic is_sfr_dir;
  logic [7:0] sfr_local;
  logic sfr_local_hit;

  assign sel_ptr = aux_q[ids_pkg::IDS_SEL_BIT] ? ptr1_q : ptr0_q;
  assign bit_byte = ids_bit_byte({1'b0, acc_addr[6:0]});
  assign is_sfr_dir = acc_op == ids_pkg::IDS_OP_DIRECT && acc_addr[7];

  // local function registers answer from inside the block
  always_comb begin
    sfr_local_hit = 1'b1;
    case (acc_addr)
      ids_pkg::IDS_ADDR_PTR_HIGH: sfr_local = sel_ptr[15:8];
      ids_pkg::IDS_ADDR_PTR_LOW: sfr_local = sel_ptr[7:0];
      ids_pkg::IDS_ADDR_AUX: sfr_local = aux_q & ids_pkg::IDS_AUX_MASK;
      ids_pkg::IDS_ADDR_PSW: sfr_local = psw_q;
      default: begin
        sfr_local = 8'h00;
        sfr_local_hit = 1'b0;
      end
    endcase
  end

  // memory address and write enables
  always_comb begin
    ram_addr = acc_addr;
    ram_we = 1'b0;
    ram_wdata = acc_wdata;
    expanded_ram_we = 1'b0;
    if (acc_valid) begin
      case (acc_op)
        ids_pkg::IDS_OP_DIRECT: begin
          ram_we = acc_write && !acc_addr[7];
          ram_addr = {1'b0, acc_addr[6:0]};
        end
        ids_pkg::IDS_OP_INDIRECT: begin
          ram_we = acc_write;
        end
        ids_pkg::IDS_OP_REG: begin
          ram_addr = {3'h0, psw_q[4:3], acc_addr[2:0]};
          ram_we = acc_write;
        end
        ids_pkg::IDS_OP_BIT: begin
          // bit area only; 80h and up are function register bits
          ram_addr = bit_byte;
          if (acc_addr[7]) begin
            ram_addr = acc_addr;
          end
          // read-modify-write needs the old byte, not known this cycle
          ram_we = 1'b0;
        end
        ids_pkg::IDS_OP_XDATA: begin
          expanded_ram_we = acc_write;
        end
        default: ram_we = 1'b0;
      endcase
    end
  end

  // state of registers, pointers and response pipeline
  always_comb begin
    psw_d = psw_q;
    aux_d = aux_q;
    ptr0_d = ptr0_q;
    ptr1_d = ptr1_q;
    src_d = IDS_SRC_NONE;
    bit_pos_d = acc_addr[2:0];
    bit_op_d = acc_op == ids_pkg::IDS_OP_BIT;
    sfr_data_d = sfr_local_hit ? sfr_local : sfr_rdata;
    sfr_wr_d = 1'b0;
    sfr_rd_d = 1'b0;
    sfr_addr_d = acc_addr;
    sfr_wd_d = acc_wdata;
    if (acc_valid) begin
      case (acc_op)
        ids_pkg::IDS_OP_DIRECT: begin
          src_d = is_sfr_dir ? IDS_SRC_SFR : IDS_SRC_RAM;
          if (is_sfr_dir && !sfr_local_hit) begin
            sfr_wr_d = acc_write;
            sfr_rd_d = !acc_write;
          end
          if (is_sfr_dir && acc_write) begin
            case (acc_addr)
              ids_pkg::IDS_ADDR_PTR_HIGH: begin
                if (aux_q[ids_pkg::IDS_SEL_BIT]) begin
                  ptr1_d[15:8] = acc_wdata;
                end else begin
                  ptr0_d[15:8] = acc_wdata;
                end
              end
              ids_pkg::IDS_ADDR_PTR_LOW: begin
                if (aux_q[ids_pkg::IDS_SEL_BIT]) begin
                  ptr1_d[7:0] = acc_wdata;
                end else begin
                  ptr0_d[7:0] = acc_wdata;
                end
              end
              ids_pkg::IDS_ADDR_AUX:
                aux_d = acc_wdata & ids_pkg::IDS_AUX_MASK;
              ids_pkg::IDS_ADDR_PSW: psw_d = acc_wdata;
              default: aux_d = aux_q;
            endcase
          end
        end
        ids_pkg::IDS_OP_INDIRECT, ids_pkg::IDS_OP_REG:
          src_d = IDS_SRC_RAM;
        ids_pkg::IDS_OP_BIT:
          src_d = acc_addr[7] ? IDS_SRC_SFR : IDS_SRC_RAM;
        ids_pkg::IDS_OP_XDATA: src_d = IDS_SRC_EXPANDED_RAM;
        default: src_d = IDS_SRC_NONE;
      endcase
    end
    // bits 1 and 2 stay zero, so the carry out of bit 0 lands in bit 1 and is masked off
    if (aux_increment) begin
      aux_d = (aux_q + 8'h01) & ids_pkg::IDS_AUX_MASK;
    end
    if (ptr_increment) begin
      if (aux_q[ids_pkg::IDS_SEL_BIT]) begin
        ptr1_d = ptr1_q + 16'h0001;
      end else begin
        ptr0_d = ptr0_q + 16'h0001;
      end
    end
    data_pointer_d = aux_d[ids_pkg::IDS_SEL_BIT] ? ptr1_d : ptr0_d;
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      psw_q <= ids_pkg::IDS_PSW_RESET;
      aux_q <= ids_pkg::IDS_AUX_RESET;
      ptr0_q <= ids_pkg::IDS_PTR_RESET;
      ptr1_q <= ids_pkg::IDS_PTR_RESET;
      src_q <= IDS_SRC_NONE;
      bit_pos_q <= 3'h0;
      bit_op_q <= 1'b0;
      sfr_data_q <= 8'h00;
      sfr_wr_q <= 1'b0;
      sfr_rd_q <= 1'b0;
      sfr_addr_q <= 8'h00;
      sfr_wd_q <= 8'h00;
      data_pointer_q <= ids_pkg::IDS_PTR_RESET;
    end else begin
      psw_q <= psw_d;
      aux_q <= aux_d;
      ptr0_q <= ptr0_d;
      ptr1_q <= ptr1_d;
      src_q <= src_d;
      bit_pos_q <= bit_pos_d;
      bit_op_q <= bit_op_d;
      sfr_data_q <= sfr_data_d;
      sfr_wr_q <= sfr_wr_d;
      sfr_rd_q <= sfr_rd_d;
      sfr_addr_q <= sfr_addr_d;
      sfr_wd_q <= sfr_wd_d;
      data_pointer_q <= data_pointer_d;
    end
  end

  ids_ram #(.DEPTH(ids_pkg::IDS_RAM_DEPTH), .AW(8)) u_iram (
    .clk_sys(clk_sys),
    .wr_en(ram_we),
    .addr(ram_addr),
    .wr_data(ram_wdata),
    .rd_data(ram_rdata)
  );

  // only the low pointer byte reaches the 256-byte space
  ids_ram #(.DEPTH(ids_pkg::IDS_EXPANDED_RAM_DEPTH), .AW(8)) u_expanded_ram (
    .clk_sys(clk_sys),
    .wr_en(expanded_ram_we),
    .addr(sel_ptr[7:0]),
    .wr_data(acc_wdata),
    .rd_data(expanded_ram_rdata)
  );

  // read data muxed into registered outputs
  logic [7:0] rd_mux;
  always_comb begin
    case (src_q)
      IDS_SRC_RAM: rd_mux = ram_rdata;
      IDS_SRC_EXPANDED_RAM: rd_mux = expanded_ram_rdata;
      IDS_SRC_SFR: rd_mux = sfr_data_q;
      default: rd_mux = 8'h00;
    endcase
  end

  logic rd_valid_q;
  logic [7:0] rd_data_q;
  logic rd_bit_q;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rd_valid_q <= 1'b0;
      rd_data_q <= 8'h00;
      rd_bit_q <= 1'b0;
    end else begin
      rd_valid_q <= src_q != IDS_SRC_NONE;
      rd_data_q <= rd_mux;
      rd_bit_q <= bit_op_q && rd_mux[bit_pos_q];
    end
  end

  assign rd_valid = rd_valid_q;
  assign rd_data = rd_data_q;
  assign rd_bit = rd_bit_q;
  assign sfr_write = sfr_wr_q;
  assign sfr_read = sfr_rd_q;
  assign sfr_addr = sfr_addr_q;
  assign sfr_wdata = sfr_wd_q;
  assign data_pointer = data_pointer_q;
  assign bank_select = psw_q[4:3];
  assign pointer_select = aux_q[ids_pkg::IDS_SEL_BIT];

  logic unused_ok;
  assign unused_ok = acc_bit_value;
endmodule // ids_data_space
`default_nettype wire

// ### test/ids_sfr_model.sv
// stand-in for the function registers kept outside the block
// assumes data is wanted in the same cycle as the request
`default_nettype none
module ids_sfr_model (
  input wire logic [7:0] sfr_addr_in,
  output logic [7:0] sfr_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  // address-dependent pattern so a stray ram hit shows
  assign sfr_rdata = sfr_addr_in ^ 8'hA5;
endmodule // ids_sfr_model
`default_nettype wire

// ### test/ids_data_space_properties.sv
// port assertions for the data space block
// assumes one clock, bound onto ids_data_space
`default_nettype none
module ids_data_space_checker (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic acc_valid,
  input wire ids_pkg::ids_op_type acc_op,
  input wire logic acc_write,
  input wire logic [7:0] acc_addr,
  input wire logic [7:0] acc_wdata,
  input wire logic ptr_increment,
  input wire logic aux_increment,
  input wire logic rd_valid,
  input wire logic sfr_write,
  input wire logic [15:0] data_pointer,
  input wire logic [1:0] bank_select,
  input wire logic pointer_select
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);
  logic dw;
  logic loc;
  assign dw = acc_valid && acc_write && acc_op == ids_pkg::IDS_OP_DIRECT;
  assign loc = acc_addr inside {8'h83, 8'h84, 8'hA2, 8'hD0};
  AST_ANSWER: assert property (acc_valid |-> ##2 rd_valid)
    else $error("answer late");
  AST_NO_STRAY: assert property (rd_valid |-> $past(acc_valid, 2))
    else $error("stray answer");
  AST_BANK_WR: assert property (dw && acc_addr == 8'hD0 |=>
    bank_select == $past(acc_wdata[4:3])) else $error("bank not set");
  AST_SEL_WR: assert property (dw && acc_addr == 8'hA2 &&
    !aux_increment |=> pointer_select == $past(acc_wdata[0]))
    else $error("select not set");
  AST_TOGGLE: assert property (aux_increment |=>
    pointer_select != $past(pointer_select)) else $error("no toggle");
  AST_PTR_INC: assert property (ptr_increment && !aux_increment |=>
    data_pointer == $past(data_pointer) + 16'h0001) else $error("bad inc");
  AST_SFR_FWD: assert property (dw && acc_addr[7] && !loc |->
    ##[1:2] sfr_write) else $error("sfr write lost");
  AST_PTR_HI: assert property (dw && acc_addr == 8'h83 &&
    !ptr_increment && !aux_increment |=>
    data_pointer[15:8] == $past(acc_wdata)) else $error("high byte");
  C_TOGGLE: cover property (aux_increment);
  C_WRAP: cover property (ptr_increment && data_pointer == 16'hFFFF);
  C_SFR: cover property (sfr_write);
endmodule // ids_data_space_checker
bind ids_data_space ids_data_space_checker chk_u (
  .clk_sys(clk_sys),
  .reset_n(reset_n),
  .acc_valid(acc_valid),
  .acc_op(acc_op),
  .acc_write(acc_write),
  .acc_addr(acc_addr),
  .acc_wdata(acc_wdata),
  .ptr_increment(ptr_increment),
  .aux_increment(aux_increment),
  .rd_valid(rd_valid),
  .sfr_write(sfr_write),
  .data_pointer(data_pointer),
  .bank_select(bank_select),
  .pointer_select(pointer_select)
);
`default_nettype wire

// ### test/ids_data_space_test.sv
// self-checking bench for the data space block
// assumes the sfr model answers in the request cycle
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin \
  failures++; $display("unexpected %0t: %h not %h", $time, a, b); end end
module ids_data_space_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam ids_pkg::ids_op_type d_op = ids_pkg::IDS_OP_DIRECT;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic acc_valid = 1'b0;
  ids_pkg::ids_op_type acc_op = ids_pkg::IDS_OP_NONE;
  logic acc_write = 1'b0;
  logic [7:0] acc_addr = 8'h00;
  logic [7:0] acc_wdata = 8'h00;
  logic ptr_increment = 1'b0;
  logic aux_increment = 1'b0;
  logic [7:0] sfr_rdata, rd_data, sfr_addr, sfr_wdata, r;
  logic rd_valid, rd_bit, sfr_write, sfr_read, pointer_select;
  logic [15:0] data_pointer;
  logic [1:0] bank_select;
  logic [9:0] exp_q[$];
  logic [9:0] e;
  int failures = 0;
  int comparisons = 0;
  int seed = 58;
  always #5 clk_sys = ~clk_sys;
  ids_data_space dut_u (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .acc_valid(acc_valid),
    .acc_op(acc_op),
    .acc_write(acc_write),
    .acc_addr(acc_addr),
    .acc_wdata(acc_wdata),
    .acc_bit_value(1'b0),
    .ptr_increment(ptr_increment),
    .aux_increment(aux_increment),
    .sfr_rdata(sfr_rdata),
    .rd_valid(rd_valid),
    .rd_data(rd_data),
    .rd_bit(rd_bit),
    .sfr_write(sfr_write),
    .sfr_read(sfr_read),
    .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata),
    .data_pointer(data_pointer),
    .bank_select(bank_select),
    .pointer_select(pointer_select)
  );
  ids_sfr_model sfr_u (.sfr_addr_in(acc_addr), .sfr_rdata(sfr_rdata));
  // note bit9 = checked, bit8 = bit result
  task automatic acc(ids_pkg::ids_op_type op, logic w, logic [7:0] a,
                     logic [7:0] d, logic [9:0] x);
    @(posedge clk_sys);
    acc_valid <= 1'b1;
    acc_op <= op;
    acc_write <= w;
    acc_addr <= a;
    acc_wdata <= d;
    exp_q.push_back(x);
  endtask
  task automatic idle;
    @(posedge clk_sys);
    acc_valid <= 1'b0;
  endtask
  task automatic pulse(logic p, logic a);
    @(posedge clk_sys);
    ptr_increment <= p;
    aux_increment <= a;
    @(posedge clk_sys);
    ptr_increment <= 1'b0;
    aux_increment <= 1'b0;
    @(negedge clk_sys);
  endtask
  task automatic tally_and_finish;
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // sampled mid-cycle so registered outputs are settled
  always @(negedge clk_sys) begin
    if (rd_valid === 1'b1) begin
      `CHK(exp_q.size() > 0, 1'b1)
      if (exp_q.size() > 0) begin
        e = exp_q.pop_front();
        if (e[9] && e[8]) `CHK(rd_bit, e[0])
        else if (e[9]) `CHK(rd_data, e[7:0])
      end
    end
  end
  initial begin
    repeat (2000) @(posedge clk_sys);
    failures++;
    tally_and_finish;
  end
  initial begin
    repeat (4) @(posedge clk_sys);
    reset_n <= 1'b1;
    r = 8'($random(seed));
    acc(d_op, 1'b1, 8'h30, r, 10'h000);
    acc(d_op, 1'b0, 8'h30, 8'h00, {2'b10, r});
    acc(ids_pkg::IDS_OP_INDIRECT, 1'b0, 8'h30, 8'h00, {2'b10, r});
    acc(ids_pkg::IDS_OP_INDIRECT, 1'b1, 8'h90, ~r, 10'h000);
    acc(ids_pkg::IDS_OP_INDIRECT, 1'b0, 8'h90, 8'h00, {2'b10, ~r});
    acc(d_op, 1'b0, 8'h90, 8'h00, {2'b10, 8'h35});
    idle;
    @(negedge clk_sys);
    `CHK({sfr_read, sfr_write, sfr_addr}, {2'b10, 8'h90})
    acc(d_op, 1'b1, 8'h90, r, 10'h000);
    idle;
    @(negedge clk_sys);
    `CHK({sfr_write, sfr_read, sfr_wdata}, {2'b10, r})
    acc(ids_pkg::IDS_OP_INDIRECT, 1'b0, 8'h90, 8'h00, {2'b10, ~r});
    for (int b = 0; b < 4; b++) begin
      r = 8'($random(seed));
      acc(d_op, 1'b1, 8'hD0, 8'(b << 3), 10'h000);
      acc(ids_pkg::IDS_OP_REG, 1'b1, 8'h03, r, 10'h000);
      acc(d_op, 1'b0, 8'(b * 8 + 3), 8'h00, {2'b10, r});
      idle;
      @(negedge clk_sys);
      `CHK(bank_select, 2'(b))
    end
    r = 8'($random(seed));
    acc(d_op, 1'b1, 8'h25, r, 10'h000);
    for (int k = 0; k < 8; k++)
      acc(ids_pkg::IDS_OP_BIT, 1'b0, 8'(8'h28 + k), 8'h00, {9'h180, r[k]});
    acc(d_op, 1'b1, 8'hA2, 8'hFF, 10'h000);
    acc(d_op, 1'b0, 8'hA2, 8'h00, {2'b10, 8'h29});
    acc(d_op, 1'b1, 8'h83, 8'hFF, 10'h000);
    acc(d_op, 1'b1, 8'h84, 8'hFF, 10'h000);
    idle;
    pulse(1'b0, 1'b1);
    `CHK({pointer_select, data_pointer}, {1'b0, 16'h0000})
    acc(d_op, 1'b1, 8'h84, 8'h40, 10'h000);
    idle;
    pulse(1'b0, 1'b1);
    `CHK({pointer_select, data_pointer}, {1'b1, 16'hFFFF})
    pulse(1'b1, 1'b0);
    `CHK(data_pointer, 16'h0000)
    pulse(1'b0, 1'b1);
    `CHK(data_pointer, 16'h0040)
    r = 8'($random(seed));
    acc(d_op, 1'b1, 8'h40, ~r, 10'h000);
    acc(ids_pkg::IDS_OP_XDATA, 1'b1, 8'h00, r, 10'h000);
    acc(ids_pkg::IDS_OP_XDATA, 1'b0, 8'h00, 8'h00, {2'b10, r});
    acc(d_op, 1'b0, 8'h40, 8'h00, {2'b10, ~r});
    acc(d_op, 1'b0, 8'h84, 8'h00, {2'b10, 8'h40});
    repeat (4) idle;
    `CHK(exp_q.size(), 0)
    tally_and_finish;
  end
endmodule // ids_data_space_test
`default_nettype wire
